// >>> hw/slcr_pkg.sv
// Package: register map, field layout, reset values and carrier types for the link controls
// How it works
// - Link enable bit 0 turns serial output off at 0, on at 1; resets to 1.
// - With link disabled: link logic reset, serializers powered down, link clocks gated.
// - With link disabled the multiframe counter stays in reset; SYSREF cannot realign it.
// - Five-bit output mode field, reset 0x02; change only with link and calibration off; writes are accepted any time, calibration_enable unused.
// - Five-bit frames-per-multiframe minus one, reset 31 (32 frames); change only disabled; writes are accepted while enabled too.
// - Manual sync bit written 0 requests synchronization like the pin; resets to 1.
// - Manual sync bit raises a request whatever sync source is selected.
// - A stuck-low selected sync pin keeps the request until sync select leaves 0.
// - Sync select bits 3:2: 0 single-ended pin, 1 timestamp input, 2 software only.
// - Sample format bit 1: 0 offset binary, 1 two's complement; resets to 1.
// - Scrambler bit 0 off by default, 1 enables; change control only while disabled; writes are accepted while enabled too.
package slcr_pkg;

    // ************************************
    // Register map
    // ************************************
    localparam logic [11:0] SLCR_OFS_LINK_ENABLE = 12'h200;
    localparam logic [11:0] SLCR_OFS_OUTPUT_MODE = 12'h201;
    localparam logic [11:0] SLCR_OFS_FRAMES = 12'h202;
    localparam logic [11:0] SLCR_OFS_MANUAL_SYNC = 12'h203;
    localparam logic [11:0] SLCR_OFS_LINK_CONTROL = 12'h204;
    localparam logic [11:0] SLCR_OFS_TEST_PATTERN = 12'h205;
    localparam logic [11:0] SLCR_OFS_SYNC_STATUS = 12'h210;
    localparam int SLCR_NUM_REGS = 6;
    localparam int SLCR_ADDR_W = 14;

    // ************************************
    // Reset values and field positions
    // ************************************
    localparam logic [7:0] SLCR_RST_LINK_ENABLE = 8'h01;
    localparam logic [7:0] SLCR_RST_OUTPUT_MODE = 8'h02;
    localparam logic [7:0] SLCR_RST_FRAMES = 8'h1F;
    localparam logic [7:0] SLCR_RST_MANUAL_SYNC = 8'h01;
    localparam logic [7:0] SLCR_RST_LINK_CONTROL = 8'h02;
    localparam logic [7:0] SLCR_RST_TEST_PATTERN = 8'h00;
    localparam int SLCR_BIT_LINK_ENABLE = 0;
    localparam int SLCR_BIT_MANUAL_SYNC = 0;
    localparam int SLCR_BIT_SCRAMBLER = 0;
    localparam int SLCR_BIT_SAMPLE_FORMAT = 1;
    localparam int SLCR_SYNC_SEL_LSB = 2;
    localparam int SLCR_FIELD5_MSB = 4;
    localparam int SLCR_TEST_MSB = 3;
    localparam logic [1:0] SLCR_SYNC_PIN = 2'h0;
    localparam logic [1:0] SLCR_SYNC_TIMESTAMP = 2'h1;
    localparam logic [1:0] SLCR_SYNC_SOFTWARE = 2'h2;
    localparam logic [31:0] SLCR_UNMAPPED_READ = 32'h0000_0000;

    // ************************************
    // Carrier types
    // ************************************
    typedef struct packed {
        logic [SLCR_ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } slcr_avmm_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } slcr_avmm_rsp_type;

    typedef struct packed {
        logic link_reset_n;
        logic serializer_power_down;
        logic link_clock_enable;
        logic multiframe_reset;
        logic sysref_align_enable;
        logic [4:0] output_mode_select;
        logic [4:0] frames_per_multiframe_minus_one;
        logic sample_format;
        logic scrambler_enable;
        logic [3:0] test_pattern_control;
        logic sync_request_n;
    } slcr_link_ctrl_type;

endpackage

// >>> hw/slcr_sync_select.sv
// Sync source selection and combination with the manual request
module slcr_sync_select
    import slcr_pkg::*;
(
    input wire logic [1:0] sync_select,
    input wire logic manual_sync_request_n,
    input wire logic single_ended_sync_pin,
    input wire logic differential_timestamp_input,
    input wire logic timestamp_receiver_enable,
    output logic sync_request_n
);
    logic source_n;

    always_comb
    begin
        case (sync_select)
            SLCR_SYNC_PIN: source_n = single_ended_sync_pin;
            SLCR_SYNC_TIMESTAMP: source_n = differential_timestamp_input |
                                             ~timestamp_receiver_enable;
            default: source_n = 1'b1;
        endcase
        sync_request_n = source_n & manual_sync_request_n;
    end
endmodule

// >>> hw/slcr_top.sv
// Serial link control registers with Avalon-MM slave and link control outputs
//
// The Avalon-MM slave port was decided locally.
module slcr_top
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire slcr_pkg::slcr_avmm_req_type avmm_req,
    output slcr_pkg::slcr_avmm_rsp_type avmm_rsp,
    input wire logic calibration_enable,
    input wire logic single_ended_sync_pin,
    input wire logic differential_timestamp_input,
    input wire logic timestamp_receiver_enable,
    input wire logic sysref,
    output slcr_pkg::slcr_link_ctrl_type link_ctrl,
    output logic sysref_to_multiframe
);
    import slcr_pkg::*;

    // ************************************
    // State
    // ************************************
    typedef enum logic [2:0] {
        SLCR_IDLE = 3'b001,
        SLCR_ACK = 3'b010,
        SLCR_DONE = 3'b100
    } slcr_bus_state_type;

    typedef struct packed {
        slcr_bus_state_type bus;
        logic [7:0] link_enable;
        logic [7:0] output_mode_select;
        logic [7:0] frames_per_multiframe;
        logic [7:0] manual_sync_request;
        logic [7:0] link_control;
        logic [7:0] test_pattern_control;
        logic [31:0] readdata;
        slcr_link_ctrl_type ctrl;
        logic sysref_out;
    } slcr_state_type;

    slcr_state_type state_q;
    slcr_state_type state_d;
    logic sync_request_n;
    logic [11:0] byte_addr;
    logic wr_ok;

    slcr_sync_select u_sync_select
    (
        .sync_select(state_q.link_control[SLCR_SYNC_SEL_LSB+1:SLCR_SYNC_SEL_LSB]),
        .manual_sync_request_n(state_q.manual_sync_request[SLCR_BIT_MANUAL_SYNC]),
        .single_ended_sync_pin(single_ended_sync_pin),
        .differential_timestamp_input(differential_timestamp_input),
        .timestamp_receiver_enable(timestamp_receiver_enable),
        .sync_request_n(sync_request_n)
    );

    // ************************************
    // Next state
    // ************************************
    always_comb
    begin
        logic en;
        en = 1'b0;
        state_d = state_q;
        // Register offset is the word address
        byte_addr = avmm_req.address[13:2];
        wr_ok = avmm_req.byteenable[0];
        case (state_q.bus)
            SLCR_IDLE:
            begin
                if (avmm_req.read || avmm_req.write)
                begin
                    state_d.bus = SLCR_ACK;
                    state_d.readdata = SLCR_UNMAPPED_READ;
                    if (avmm_req.address[13:12] == 2'b00)
                    begin
                        case (byte_addr)
                            SLCR_OFS_LINK_ENABLE:
                            begin
                                state_d.readdata[7:0] = state_q.link_enable;
                                if (avmm_req.write && wr_ok)
                                    state_d.link_enable = avmm_req.writedata[7:0];
                            end
                            SLCR_OFS_OUTPUT_MODE:
                            begin
                                state_d.readdata[7:0] = state_q.output_mode_select;
                                if (avmm_req.write && wr_ok)
                                    state_d.output_mode_select = avmm_req.writedata[7:0];
                            end
                            SLCR_OFS_FRAMES:
                            begin
                                state_d.readdata[7:0] = state_q.frames_per_multiframe;
                                if (avmm_req.write && wr_ok)
                                    state_d.frames_per_multiframe = avmm_req.writedata[7:0];
                            end
                            SLCR_OFS_MANUAL_SYNC:
                            begin
                                state_d.readdata[7:0] = state_q.manual_sync_request;
                                if (avmm_req.write && wr_ok)
                                    state_d.manual_sync_request = avmm_req.writedata[7:0];
                            end
                            SLCR_OFS_LINK_CONTROL:
                            begin
                                state_d.readdata[7:0] = state_q.link_control;
                                if (avmm_req.write && wr_ok)
                                    state_d.link_control = avmm_req.writedata[7:0];
                            end
                            SLCR_OFS_TEST_PATTERN:
                            begin
                                state_d.readdata[7:0] = state_q.test_pattern_control;
                                if (avmm_req.write && wr_ok)
                                    state_d.test_pattern_control = avmm_req.writedata[7:0];
                            end
                            SLCR_OFS_SYNC_STATUS:
                            begin
                                state_d.readdata[0] = state_q.ctrl.sync_request_n;
                                state_d.readdata[1] = state_q.ctrl.link_reset_n;
                            end
                            default:
                            begin
                                state_d.readdata = SLCR_UNMAPPED_READ;
                            end
                        endcase
                    end
                end
            end
            SLCR_ACK:
            begin
                state_d.bus = SLCR_DONE;
            end
            SLCR_DONE:
            begin
                state_d.bus = SLCR_IDLE;
            end
            default:
            begin
                state_d.bus = SLCR_IDLE;
            end
        endcase

        // Link control outputs
        en = state_q.link_enable[SLCR_BIT_LINK_ENABLE];
        state_d.ctrl.link_reset_n = en;
        state_d.ctrl.serializer_power_down = ~en;
        state_d.ctrl.link_clock_enable = en;
        state_d.ctrl.multiframe_reset = ~en;
        state_d.ctrl.sysref_align_enable = en;
        state_d.sysref_out = sysref & en;
        state_d.ctrl.output_mode_select =
            state_q.output_mode_select[SLCR_FIELD5_MSB:0];
        state_d.ctrl.frames_per_multiframe_minus_one =
            state_q.frames_per_multiframe[SLCR_FIELD5_MSB:0];
        state_d.ctrl.sample_format = state_q.link_control[SLCR_BIT_SAMPLE_FORMAT];
        state_d.ctrl.scrambler_enable = state_q.link_control[SLCR_BIT_SCRAMBLER];
        state_d.ctrl.test_pattern_control = state_q.test_pattern_control[SLCR_TEST_MSB:0];
        state_d.ctrl.sync_request_n = sync_request_n;
    end

    // ************************************
    // Registers
    // ************************************
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_q.bus <= SLCR_IDLE;
            state_q.link_enable <= SLCR_RST_LINK_ENABLE;
            state_q.output_mode_select <= SLCR_RST_OUTPUT_MODE;
            state_q.frames_per_multiframe <= SLCR_RST_FRAMES;
            state_q.manual_sync_request <= SLCR_RST_MANUAL_SYNC;
            state_q.link_control <= SLCR_RST_LINK_CONTROL;
            state_q.test_pattern_control <= SLCR_RST_TEST_PATTERN;
            state_q.readdata <= SLCR_UNMAPPED_READ;
            state_q.ctrl <= '0;
            state_q.sysref_out <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
        end
    end

    always_comb
    begin
        avmm_rsp.readdata = state_q.readdata;
        avmm_rsp.waitrequest = state_q.bus != SLCR_ACK;
        link_ctrl = state_q.ctrl;
        sysref_to_multiframe = state_q.sysref_out;
    end
endmodule

// >>> tb/slcr_asserts.sv
// Port assertions for the link control register block
module slcr_asserts
(
    input wire logic clk,
    input wire logic rstn,
    input wire slcr_pkg::slcr_avmm_req_type avmm_req,
    input wire logic single_ended_sync_pin,
    input wire logic differential_timestamp_input,
    input wire logic timestamp_receiver_enable,
    input wire logic sysref,
    input wire slcr_pkg::slcr_link_ctrl_type link_ctrl,
    input wire logic sysref_to_multiframe
);
    import slcr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    function automatic logic wr_at(slcr_avmm_req_type r, logic [11:0] ofs);
        return r.write && r.byteenable[0] && r.address == {ofs, 2'h0};
    endfunction
    sequence s_quiet;
        !avmm_req.write && $stable({single_ended_sync_pin, differential_timestamp_input,
            timestamp_receiver_enable});
    endsequence
    property p_link_gate;
        $past(rstn) |-> {link_ctrl.link_clock_enable, link_ctrl.sysref_align_enable,
            ~link_ctrl.serializer_power_down, ~link_ctrl.multiframe_reset} == {4{link_ctrl.link_reset_n}};
    endproperty
    a_link_gate: assert property (p_link_gate) else $error("link gating mismatch");
    property p_sysref_block;
        link_ctrl.multiframe_reset && $past(link_ctrl.multiframe_reset) |-> !sysref_to_multiframe;
    endproperty
    a_sysref_block: assert property (p_sysref_block) else $error("sysref leaked");
    property p_sysref_pass;
        $past(rstn, 2) && !link_ctrl.multiframe_reset && !$past(link_ctrl.multiframe_reset)
            |-> sysref_to_multiframe == $past(sysref);
    endproperty
    a_sysref_pass: assert property (p_sysref_pass) else $error("sysref not passed");
    property p_enable_write;
        $past(rstn, 2) && $changed(link_ctrl.link_reset_n)
            |-> wr_at($past(avmm_req, 2), SLCR_OFS_LINK_ENABLE);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable moved alone");
    property p_mode_write;
        $past(rstn, 2) && $changed(link_ctrl.output_mode_select)
            |-> wr_at($past(avmm_req, 2), SLCR_OFS_OUTPUT_MODE);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode moved alone");
    property p_frames_write;
        $past(rstn, 2) && $changed(link_ctrl.frames_per_multiframe_minus_one)
            |-> wr_at($past(avmm_req, 2), SLCR_OFS_FRAMES);
    endproperty
    a_frames_write: assert property (p_frames_write) else $error("frames moved alone");
    property p_ctrl_write;
        $past(rstn, 2) && $changed({link_ctrl.sample_format, link_ctrl.scrambler_enable})
            |-> wr_at($past(avmm_req, 2), SLCR_OFS_LINK_CONTROL);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control moved alone");
    property p_sync_hold;
        s_quiet [*3] |=> $stable(link_ctrl.sync_request_n);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync request moved alone");
    c_link_off: cover property (link_ctrl.multiframe_reset && sysref);
    c_sync_req: cover property (!link_ctrl.sync_request_n);
    c_sysref_pass: cover property (sysref_to_multiframe);
endmodule

bind slcr_top slcr_asserts u_asserts (.clk(clk), .rstn(rstn), .avmm_req(avmm_req),
    .single_ended_sync_pin(single_ended_sync_pin),
    .differential_timestamp_input(differential_timestamp_input),
    .timestamp_receiver_enable(timestamp_receiver_enable), .sysref(sysref),
    .link_ctrl(link_ctrl), .sysref_to_multiframe(sysref_to_multiframe));

// >>> tb/slcr_rx_model.sv
// Far-side receiver model driving the two active-low sync lines
module slcr_rx_model
#(
    parameter int DLY = 2
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] want_sync,
    output logic [1:0] sync_n
);
    import slcr_pkg::*;
    logic [DLY*2-1:0] pipe_q;
    always_ff @(posedge clk)
    begin
        pipe_q <= rstn ? {pipe_q[DLY*2-3:0], want_sync} : '0;
    end
    // Lines idle high; a request pulls low after DLY cycles
    assign sync_n = ~pipe_q[DLY*2-1 -: 2];
endmodule

// >>> tb/tb_serial_link_control_regs.sv
// Testbench for the serial link control register block
module tb_serial_link_control_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import slcr_pkg::*;
    typedef struct packed {logic [11:0] ofs; logic [7:0] wd; logic [7:0] exp;} slcr_row_type;
    localparam slcr_row_type ROWS [6] = '{'{SLCR_OFS_OUTPUT_MODE, 8'hE5, 8'hE5},
        '{SLCR_OFS_FRAMES, 8'h6A, 8'h6A}, '{SLCR_OFS_MANUAL_SYNC, 8'hFE, 8'hFE},
        '{SLCR_OFS_LINK_CONTROL, 8'hF1, 8'hF1}, '{SLCR_OFS_TEST_PATTERN, 8'hA7, 8'hA7},
        '{12'h206, 8'h55, 8'h00}};
    localparam logic [7:0] RST [6] = '{SLCR_RST_LINK_ENABLE, SLCR_RST_OUTPUT_MODE,
        SLCR_RST_FRAMES, SLCR_RST_MANUAL_SYNC, SLCR_RST_LINK_CONTROL, SLCR_RST_TEST_PATTERN};
    // Sync rows: select, manual, timestamp low, pin low, receiver enable, expected request_n
    localparam logic [6:0] SYNC [8] = '{7'h19, 7'h14, 7'h02, 7'h3A, 7'h39, 7'h37, 7'h5F, 7'h42};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic calibration_enable = 1'b0;
    logic timestamp_receiver_enable = 1'b0;
    logic sysref = 1'b0;
    logic [1:0] want_sync = 2'h0;
    logic [1:0] sel;
    logic [1:0] ws;
    logic man, rxen, e;
    logic [7:0] rd;
    int failures = 0;
    int num_checks = 0;
    slcr_avmm_req_type avmm_req = '0;
    slcr_avmm_rsp_type avmm_rsp;
    slcr_link_ctrl_type link_ctrl;
    logic sysref_to_multiframe;
    wire logic single_ended_sync_pin;
    wire logic differential_timestamp_input;
    initial forever #25 clk = ~clk;
    slcr_top dut (.clk(clk), .rstn(rstn), .ce(1'b1), .avmm_req(avmm_req), .avmm_rsp(avmm_rsp),
        .calibration_enable(calibration_enable), .single_ended_sync_pin(single_ended_sync_pin),
        .differential_timestamp_input(differential_timestamp_input),
        .timestamp_receiver_enable(timestamp_receiver_enable), .sysref(sysref),
        .link_ctrl(link_ctrl), .sysref_to_multiframe(sysref_to_multiframe));
    slcr_rx_model u_rx (.clk(clk), .rstn(rstn), .want_sync(want_sync),
        .sync_n({differential_timestamp_input, single_ended_sync_pin}));
    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] ofs, input logic [7:0] wd);
        int n;
        n = 0;
        avmm_req <= '{address: {ofs, 2'h0}, read: ~wr, write: wr, writedata: {24'h0, wd},
            byteenable: 4'hF};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avmm_rsp.waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            failures++;
            finish_test();
        end
        else
        begin
            rd = avmm_rsp.readdata[7:0];
            avmm_req.read <= 1'b0;
            avmm_req.write <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic check_link(input logic en);
        check("link gating", {link_ctrl.link_reset_n, link_ctrl.serializer_power_down,
            link_ctrl.link_clock_enable, link_ctrl.multiframe_reset,
            link_ctrl.sysref_align_enable}, {en, ~en, en, ~en, en});
    endtask
    task automatic pulse_sysref(input logic exp);
        sysref <= 1'b1;
        repeat (3) @(posedge clk);
        check("sysref copy", sysref_to_multiframe, exp);
        sysref <= 1'b0;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < SLCR_NUM_REGS; i++)
        begin
            bus(1'b0, 12'(SLCR_OFS_LINK_ENABLE + i), 8'h00);
            check("reset value", rd, RST[i]);
        end
        check("fields", {link_ctrl.output_mode_select, link_ctrl.frames_per_multiframe_minus_one,
            link_ctrl.sample_format, link_ctrl.scrambler_enable, link_ctrl.sync_request_n},
            {5'h02, 5'h1F, 1'b1, 1'b0, 1'b1});
        check_link(1'b1);
        bus(1'b1, SLCR_OFS_LINK_ENABLE, 8'h00);
        check_link(1'b0);
        pulse_sysref(1'b0);
        foreach (ROWS[i])
        begin
            bus(1'b1, ROWS[i].ofs, ROWS[i].wd);
            bus(1'b0, ROWS[i].ofs, 8'h00);
            check("readback", rd, ROWS[i].exp);
        end
        check("fields", {link_ctrl.output_mode_select, link_ctrl.frames_per_multiframe_minus_one,
            link_ctrl.sample_format, link_ctrl.scrambler_enable, link_ctrl.test_pattern_control,
            link_ctrl.sync_request_n}, {5'h05, 5'h0A, 1'b0, 1'b1, 4'h7, 1'b0});
        foreach (SYNC[i])
        begin
            {sel, man, ws, rxen, e} = SYNC[i];
            want_sync <= ws;
            timestamp_receiver_enable <= rxen;
            bus(1'b1, SLCR_OFS_LINK_CONTROL, {4'hF, sel, 2'h2});
            bus(1'b1, SLCR_OFS_MANUAL_SYNC, {7'h0, man});
            repeat (3) @(posedge clk);
            check("sync request", link_ctrl.sync_request_n, e);
        end
        calibration_enable <= 1'b1;
        bus(1'b1, SLCR_OFS_LINK_ENABLE, 8'hFF);
        check_link(1'b1);
        pulse_sysref(1'b1);
        bus(1'b1, SLCR_OFS_LINK_ENABLE, 8'h00);
        calibration_enable <= 1'b0;
        check_link(1'b0);
        finish_test();
    end
endmodule
